// file: test/nit_host_model.sv
`timescale 1ns/10ps
module nit_host_model (
	input  wire logic       core_clk,
	output logic            cmd_valid  = 1'b0,
	output logic            addr_valid = 1'b0,
	output logic            data_valid = 1'b0,
	output logic            read_req   = 1'b0,
	output logic      [7:0] bus_byte   = 8'h00
);
	// Kind 4 is a free cycle; released bus shows the inverse byte
	task automatic cyc(input logic [2:0] k, input logic [7:0] b);
		@(negedge core_clk);
		cmd_valid = k == 3'd0;
		addr_valid = k == 3'd1;
		data_valid = k == 3'd2;
		read_req = k == 3'd3;
		bus_byte = k == 3'd4 ? ~bus_byte : b;
	endtask

	// One write-type operation; caller keeps one type per sequence
	task automatic op(input logic [7:0] c, input logic [1:0] sel, input logic [5:0] pg,
		input int nd, input logic [7:0] fin);
		int k;
		cyc(3'd0, c);
		cyc(3'd4, 8'h00);
		if (c != 8'h60) begin
			cyc(3'd1, 8'h00);
			cyc(3'd1, 8'h00);
		end
		cyc(3'd1, {sel, pg});
		cyc(3'd1, 8'h00);
		cyc(3'd1, 8'h00);
		for (k = 0; k < nd; k++)
			cyc(3'd2, 8'(k));
		cyc(3'd0, fin);
		cyc(3'd4, 8'h00);
		cyc(3'd4, 8'h00);
	endtask
endmodule

// file: test/nit_target_chk.sv
`timescale 1ns/10ps
module nit_target_chk #(
	parameter int POWER_UP_CYCLES = 20,
	parameter int UNIT_W          = 1
) (
	input wire logic              core_clk,
	input wire logic              rst,
	input wire logic              cmd_valid,
	input wire logic [7:0]        bus_byte,
	input wire logic              wp_n,
	input wire logic              overlap_mode,
	input wire logic              rdy_busy,
	input wire logic [7:0]        unit_status_byte,
	input wire logic              status_valid,
	input wire logic              array_start,
	input wire logic [7:0]        last_command_record,
	input wire logic [UNIT_W-1:0] selected_unit,
	input wire logic              status_output_flag,
	input wire logic              copyback_active
);
	localparam int PU_MAX = POWER_UP_CYCLES + 4;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence s_cmd(logic [7:0] c);
		cmd_valid && bus_byte == c;
	endsequence
	sequence s_power_up;
		(!rdy_busy)[*8] ##[1:PU_MAX] rdy_busy;
	endsequence
	sequence s_copyback_span;
		copyback_active ##[1:40] !copyback_active;
	endsequence
	AST_POWER_UP: assert property ($fell(rst) |-> s_power_up)
		else $error("ready late after power-up");
	AST_FLAGS_CLEAR: assert property ($fell(rst) |-> selected_unit == '0 &&
		!status_output_flag && !copyback_active) else $error("flags not cleared");
	AST_LAST_CMD_KEEP: assert property (s_cmd(8'h70) or s_cmd(8'h78) |=>
		$stable(last_command_record)[*3]) else $error("status changed last command");
	AST_WP_DISCARD: assert property ((s_cmd(8'h80) or s_cmd(8'h60)) ##0 !wp_n |=>
		(!array_start)[*8]) else $error("protected command ran");
	// Gap of 8 matches the shortened array time in the bench
	AST_START_GAP: assert property (array_start |=> (!array_start)[*8])
		else $error("array ops overlap");
	AST_OVERLAP_START: assert property ((s_cmd(8'h11) or s_cmd(8'h10) or
		s_cmd(8'h15)) ##0 overlap_mode |-> ##2 array_start)
		else $error("overlapped op not started");
	AST_CONC_DEFER: assert property ((s_cmd(8'hd1) or s_cmd(8'h11)) ##0
		!overlap_mode |=> (!array_start)[*4])
		else $error("array used before final confirm");
	AST_CONC_RUN: assert property ((s_cmd(8'hd0) or s_cmd(8'h10)) ##0
		(wp_n && !overlap_mode) |-> ##[1:4] array_start)
		else $error("final confirm started nothing");
	AST_COPYBACK_SPAN: assert property (s_cmd(8'h85) |-> ##2 s_copyback_span)
		else $error("copyback flag not set or not cleared in idle");
	AST_STATUS_SHARED: assert property (status_valid |->
		unit_status_byte[4:2] == 3'h0 && unit_status_byte[7] == wp_n)
		else $error("shared status bits wrong");
endmodule

bind nit_target nit_target_chk #(.POWER_UP_CYCLES(POWER_UP_CYCLES), .UNIT_W(UNIT_W)) i_chk (
	.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .bus_byte(bus_byte),
	.wp_n(wp_n), .overlap_mode(overlap_mode), .rdy_busy(rdy_busy),
	.unit_status_byte(unit_status_byte), .status_valid(status_valid),
	.array_start(array_start), .last_command_record(last_command_record),
	.selected_unit(selected_unit), .status_output_flag(status_output_flag),
	.copyback_active(copyback_active)
);

// file: test/nit_target_tb.sv
`timescale 1ns/10ps
module nit_target_tb;
	logic        core_clk, rst, cmd_valid, addr_valid, data_valid, read_req, wp_n;
	logic        overlap_mode, array_fail, rdy_busy, status_valid, array_start;
	logic        status_output_flag, column_change_allowed, copyback_active, enh_req;
	logic [7:0]  bus_byte, unit_status_byte, last_command_record, return_state;
	logic [1:0]  array_sel, array_kind, kind_exp, sa, sb;
	logic [0:0]  selected_unit;
	logic [5:0]  pg;
	logic [31:0] rnd;
	logic        cur[4], prv[4];
	logic [1:0]  q[$];
	int          mismatches, checks_done, cycles, i;

	nit_target #(.POWER_UP_CYCLES(20), .RESET_CYCLES(8), .ARRAY_CYCLES(8)) i_dut (
		.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .addr_valid(addr_valid),
		.data_valid(data_valid), .bus_byte(bus_byte), .read_req(read_req), .wp_n(wp_n),
		.overlap_mode(overlap_mode), .array_fail(array_fail), .rdy_busy(rdy_busy),
		.unit_status_byte(unit_status_byte), .status_valid(status_valid),
		.array_start(array_start), .array_sel(array_sel), .array_kind(array_kind),
		.last_command_record(last_command_record), .selected_unit(selected_unit),
		.status_output_flag(status_output_flag), .copyback_active(copyback_active),
		.column_change_allowed(column_change_allowed), .enhanced_status_required(enh_req),
		.return_state(return_state));
	nit_host_model i_host (.core_clk(core_clk), .cmd_valid(cmd_valid), .read_req(read_req),
		.addr_valid(addr_valid), .data_valid(data_valid), .bus_byte(bus_byte));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [7:0] sx(input logic [1:0] s);
		return {wp_n, 2'b11, 3'b000, prv[s], cur[s]};
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		if (mismatches == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) i_host.cyc(3'd4, 8'h00);
	endtask

	task automatic wait_rdy();
		int k;
		for (k = 0; k < 100 && rdy_busy !== 1'b1; k++)
			idle(1);
		chk(rdy_busy, 1'b1);
		idle(2);
	endtask

	task automatic rd_status(input logic [7:0] exp);
		int k;
		i_host.cyc(3'd0, 8'h70);
		idle(2);
		i_host.cyc(3'd3, 8'h00);
		for (k = 0; k < 3 && status_valid !== 1'b1; k++)
			idle(1);
		chk(status_valid, 1'b1);
		chk(unit_status_byte, exp);
		idle(1);
	endtask

	// Fail result of each started op is random; model keeps it per selector
	always @(negedge core_clk) begin
		if (array_start === 1'b1) begin
			chk(array_sel, q.size() > 0 ? q.pop_front() : 2'bxx);
			chk(array_kind, kind_exp);
			rnd = lfsr(rnd);
			array_fail <= rnd[0];
			prv[array_sel] = cur[array_sel];
			cur[array_sel] = rnd[0];
		end
	end

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			end_of_test();
		end
	end

	initial begin
		rst = 1'b1;
		wp_n = 1'b1;
		overlap_mode = 1'b0;
		array_fail = 1'b0;
		rnd = 32'h977393c2;
		mismatches = 0;
		checks_done = 0;
		cycles = 0;
		for (i = 0; i < 4; i++) begin
			cur[i] = 1'b0;
			prv[i] = 1'b0;
		end
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		chk(rdy_busy, 1'b0);
		chk(return_state, 8'h01);
		chk({status_output_flag, column_change_allowed, copyback_active}, 8'h00);
		chk({enh_req, selected_unit}, 8'h00);
		i_host.cyc(3'd0, 8'h70);
		idle(4);
		chk(status_output_flag, 1'b0);
		chk(return_state, 8'h01);
		wait_rdy();
		i_host.cyc(3'd0, 8'hff);
		idle(3);
		chk(rdy_busy, 1'b0);
		wait_rdy();
		chk(last_command_record, 8'hff);
		chk(return_state, 8'h08);
		chk(copyback_active, 1'b0);
		rnd = lfsr(rnd);
		sa = rnd[1:0];
		sb = sa + 2'd1 + {1'b0, rnd[2]};
		pg = rnd[8:3];
		overlap_mode = 1'b1;
		kind_exp = 2'd0;
		q.push_back(sa);
		q.push_back(sb);
		i_host.op(8'h80, sa, pg, 12, 8'h11);
		i_host.op(8'h80, sb, pg, 12, 8'h15);
		idle(12);
		chk(8'(q.size()), 8'h00);
		chk(last_command_record, 8'h80);
		rd_status(sx(sb));
		chk(last_command_record, 8'h80);
		overlap_mode = 1'b0;
		kind_exp = 2'd2;
		q.push_back(sa < sb ? sa : sb);
		q.push_back(sa < sb ? sb : sa);
		i_host.op(8'h60, sb, pg, 0, 8'hd1);
		chk(8'(q.size()), 8'h02);
		i_host.op(8'h60, sa, pg, 0, 8'hd0);
		idle(1);
		chk(rdy_busy, 1'b0);
		wait_rdy();
		chk(last_command_record, 8'h60);
		rd_status(sx(sa));
		kind_exp = 2'd1;
		q.push_back(sa < sb ? sa : sb);
		q.push_back(sa < sb ? sb : sa);
		i_host.op(8'h00, sa, pg, 0, 8'h35);
		i_host.op(8'h00, sb, pg + 6'd1, 0, 8'h35);
		i_host.op(8'h85, sa, pg, 0, 8'h11);
		chk(8'(q.size()), 8'h02);
		i_host.op(8'h85, sb, pg, 0, 8'h10);
		idle(1);
		chk(rdy_busy, 1'b0);
		wait_rdy();
		chk(copyback_active, 1'b0);
		chk(last_command_record, 8'h85);
		wp_n = 1'b0;
		rd_status(sx(sb));
		for (i = 0; i < 2; i++) begin
			i_host.op(i ? 8'h60 : 8'h80, sa, pg, i ? 0 : 2, i ? 8'hd0 : 8'h10);
			idle(10);
			chk(return_state, 8'h08);
		end
		wp_n = 1'b1;
		end_of_test();
	end
endmodule

// file: verilog/nit_fail_mem.sv
`timescale 1ns/10ps
// Per-selector fail pair {previous, current}; two registered read ports
module nit_fail_mem #(
	parameter int ADDR_W = 2,
	parameter int DATA_W = 2
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic [ADDR_W-1:0] rd_a_addr,
	output logic      [DATA_W-1:0] rd_a_data,
	input  wire logic [ADDR_W-1:0] rd_b_addr,
	output logic      [DATA_W-1:0] rd_b_data
);
	logic [DATA_W-1:0] mem_reg [2**ADDR_W];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < 2**ADDR_W; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (wr_en) begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_a_data <= '0;
			rd_b_data <= '0;
		end else begin
			rd_a_data <= mem_reg[rd_a_addr];
			rd_b_data <= mem_reg[rd_b_addr];
		end
	end
endmodule

// file: verilog/nit_pkg.sv
package nit_pkg;
	localparam logic [7:0] CMD_RESET      = 8'hff;
	localparam logic [7:0] CMD_STATUS     = 8'h70;
	localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
	localparam logic [7:0] CMD_PROGRAM    = 8'h80;
	localparam logic [7:0] CMD_COPYBACK   = 8'h85;
	localparam logic [7:0] CMD_ERASE      = 8'h60;
	localparam logic [7:0] CMD_PROG_NEXT  = 8'h11;
	localparam logic [7:0] CMD_PROG_FINAL = 8'h10;
	localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
	localparam logic [7:0] CMD_ERASE_NEXT = 8'hd1;
	localparam logic [7:0] CMD_ERASE_FIN  = 8'hd0;

	localparam int BIT_FAIL       = 0;
	localparam int BIT_PREV_FAIL  = 1;
	localparam int BIT_VENDOR     = 4;
	localparam int BIT_ARRAY_RDY  = 5;
	localparam int BIT_READY      = 6;
	localparam int BIT_WP         = 7;

	localparam int COL_CYCLES = 2;
	localparam int ROW_CYCLES = 3;

	localparam int CLK_MHZ          = 10;
	localparam int POWER_UP_TIME_US = 1000;
	// Longest time, so rounded down
	localparam int POWER_UP_CYCLES  = POWER_UP_TIME_US * CLK_MHZ;
	localparam int RESET_CYCLES     = 32;
	localparam int ARRAY_CYCLES     = 64;

	typedef enum logic [7:0] {
		ST_POWER_UP    = 8'h01,
		ST_POWER_READY = 8'h02,
		ST_RESET       = 8'h04,
		ST_IDLE        = 8'h08,
		ST_DECODE      = 8'h10,
		ST_ADDR        = 8'h20,
		ST_DATA        = 8'h40,
		ST_ERASE_CONF  = 8'h80
	} nit_state_t;

	typedef enum logic [1:0] {
		OP_PROGRAM  = 2'h0,
		OP_COPYBACK = 2'h1,
		OP_ERASE    = 2'h2
	} nit_op_t;
endpackage

// file: verilog/nit_target.sv
`timescale 1ns/10ps
// Functional notes
// - No interleaved reads exist
// - Concurrent style defers array until final confirm
// - Overlapped style starts each operation as soon as the array is idle
// - Fail bits per selector, others shared
// - Erase uses 60h/D1h pairs, closes 60h/D0h
// - Hold state when no exit applies
// - Power-on clears flags, unit zero
// - Last command ignores 70h and 78h
// - Busy at power-up, ready within 1 ms, FFh only
// - Idle clears copyback, sets return state
// - Write-protect low discards 80h and 60h
// - Ready/busy is AND of unit ready bits
module nit_target #(
	parameter int SEL_W           = 2,
	parameter int PAGE_BITS       = 6,
	parameter int UNIT_W          = 1,
	parameter int POWER_UP_CYCLES = nit_pkg::POWER_UP_CYCLES,
	parameter int RESET_CYCLES    = nit_pkg::RESET_CYCLES,
	parameter int ARRAY_CYCLES    = nit_pkg::ARRAY_CYCLES
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              cmd_valid,
	input  wire logic              addr_valid,
	input  wire logic              data_valid,
	input  wire logic [7:0]        bus_byte,
	input  wire logic              read_req,
	input  wire logic              wp_n,
	input  wire logic              overlap_mode,
	input  wire logic              array_fail,
	output logic                   rdy_busy,
	output logic [7:0]             unit_status_byte,
	output logic                   status_valid,
	output logic                   array_start,
	output logic [SEL_W-1:0]       array_sel,
	output logic [1:0]             array_kind,
	output logic [7:0]             last_command_record,
	output logic [UNIT_W-1:0]      selected_unit,
	output logic                   status_output_flag,
	output logic                   column_change_allowed,
	output logic                   copyback_active,
	output logic                   enhanced_status_required,
	output logic [7:0]             return_state
);
	localparam int NSEL = 2**SEL_W;

	function automatic logic [SEL_W-1:0] sel_of(input logic [23:0] row);
		return row[PAGE_BITS +: SEL_W];
	endfunction

	function automatic logic [SEL_W-1:0] lowest(input logic [NSEL-1:0] m);
		logic [SEL_W-1:0] r;
		r = '0;
		for (int i = NSEL - 1; i >= 0; i--) begin
			if (m[i]) begin
				r = SEL_W'(i);
			end
		end
		return r;
	endfunction

	nit_pkg::nit_state_t state_reg;
	logic [13:0]       wait_cnt_reg;
	logic [7:0]        cmd_reg;
	logic [2:0]        addr_cnt_reg;
	logic [23:0]       row_reg;
	logic [1:0]        op_reg;
	logic [NSEL-1:0]   pending_reg;
	logic              go_reg;
	logic              run_reg;
	logic [7:0]        run_cnt_reg;
	logic [SEL_W-1:0]  run_sel_reg;
	logic [SEL_W-1:0]  stat_sel_reg;
	logic              wp_seen_reg;
	logic              unit_rdy_reg;
	logic [1:0]        fail_run;
	logic [1:0]        fail_stat;
	logic              op_done;
	logic              op_final;
	logic              start_now;

	// Each accepted sub-operation and the sequence's closing confirm
	assign op_done = (state_reg == nit_pkg::ST_DATA) && cmd_valid &&
		(bus_byte == nit_pkg::CMD_PROG_NEXT || bus_byte == nit_pkg::CMD_PROG_FINAL ||
		 bus_byte == nit_pkg::CMD_PROG_CACHE) ||
		(state_reg == nit_pkg::ST_ERASE_CONF) && cmd_valid &&
		(bus_byte == nit_pkg::CMD_ERASE_NEXT || bus_byte == nit_pkg::CMD_ERASE_FIN);
	assign op_final = op_done && (bus_byte == nit_pkg::CMD_PROG_FINAL ||
		bus_byte == nit_pkg::CMD_PROG_CACHE || bus_byte == nit_pkg::CMD_ERASE_FIN);
	// Overlapped starts once the array is idle, concurrent waits for the final confirm
	assign start_now = !run_reg && (pending_reg != '0) && (overlap_mode || go_reg);

	nit_fail_mem #(
		.ADDR_W (SEL_W),
		.DATA_W (2)
	) u_fail_mem (
		.core_clk  (core_clk),
		.rst       (rst),
		.wr_en     (run_reg && run_cnt_reg == 8'h0),
		.wr_addr   (run_sel_reg),
		.wr_data   ({fail_run[0], array_fail}),
		.rd_a_addr (run_sel_reg),
		.rd_a_data (fail_run),
		.rd_b_addr (stat_sel_reg),
		.rd_b_data (fail_stat)
	);

	// Target flow; any state without a matching exit holds
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg    <= nit_pkg::ST_POWER_UP;
			wait_cnt_reg <= '0;
			cmd_reg      <= '0;
			addr_cnt_reg <= '0;
			row_reg      <= '0;
			op_reg       <= '0;
		end else if (cmd_valid && bus_byte == nit_pkg::CMD_RESET &&
				state_reg != nit_pkg::ST_POWER_UP) begin
			state_reg    <= nit_pkg::ST_RESET;
			wait_cnt_reg <= 14'(RESET_CYCLES);
		end else begin
			case (state_reg)
			nit_pkg::ST_POWER_UP: begin
				wait_cnt_reg <= wait_cnt_reg + 14'h1;
				if (wait_cnt_reg >= 14'(POWER_UP_CYCLES - 1)) begin
					state_reg <= nit_pkg::ST_POWER_READY;
				end
			end
			nit_pkg::ST_POWER_READY: begin
				state_reg <= state_reg;
			end
			nit_pkg::ST_RESET: begin
				if (wait_cnt_reg == '0) begin
					state_reg <= nit_pkg::ST_IDLE;
				end else begin
					wait_cnt_reg <= wait_cnt_reg - 14'h1;
				end
			end
			nit_pkg::ST_IDLE: begin
				if (cmd_valid) begin
					cmd_reg   <= bus_byte;
					state_reg <= nit_pkg::ST_DECODE;
				end
			end
			nit_pkg::ST_DECODE: begin
				addr_cnt_reg <= '0;
				case (cmd_reg)
				nit_pkg::CMD_PROGRAM, nit_pkg::CMD_COPYBACK, nit_pkg::CMD_ERASE: begin
					if (!wp_n && cmd_reg != nit_pkg::CMD_COPYBACK) begin
						state_reg <= nit_pkg::ST_IDLE;
					end else begin
						state_reg <= nit_pkg::ST_ADDR;
						op_reg <= (cmd_reg == nit_pkg::CMD_ERASE) ? nit_pkg::OP_ERASE :
							(cmd_reg == nit_pkg::CMD_COPYBACK) ? nit_pkg::OP_COPYBACK :
							nit_pkg::OP_PROGRAM;
						addr_cnt_reg <= (cmd_reg == nit_pkg::CMD_ERASE) ?
							3'(nit_pkg::ROW_CYCLES) :
							3'(nit_pkg::COL_CYCLES + nit_pkg::ROW_CYCLES);
					end
				end
				// Reads have no interleaved form here
				default: state_reg <= nit_pkg::ST_IDLE;
				endcase
			end
			nit_pkg::ST_ADDR: begin
				if (addr_valid) begin
					addr_cnt_reg <= addr_cnt_reg - 3'h1;
					if (addr_cnt_reg <= 3'(nit_pkg::ROW_CYCLES)) begin
						row_reg <= {bus_byte, row_reg[23:8]};
					end
					if (addr_cnt_reg == 3'h1) begin
						state_reg <= (op_reg == nit_pkg::OP_ERASE) ?
							nit_pkg::ST_ERASE_CONF : nit_pkg::ST_DATA;
					end
				end
			end
			nit_pkg::ST_DATA, nit_pkg::ST_ERASE_CONF: begin
				// Data cycles are ignored; only the confirm command is decoded
				if (op_done) begin
					state_reg <= nit_pkg::ST_IDLE;
				end
			end
			default: state_reg <= nit_pkg::ST_POWER_UP;
			endcase
		end
	end

	// Selector queue and array engine
	always_ff @(posedge core_clk) begin
		if (rst || state_reg == nit_pkg::ST_RESET) begin
			pending_reg  <= '0;
			go_reg       <= 1'b0;
			run_reg      <= 1'b0;
			run_cnt_reg  <= '0;
			run_sel_reg  <= '0;
			stat_sel_reg <= '0;
			array_start  <= 1'b0;
			array_sel    <= '0;
			array_kind   <= '0;
		end else begin
			array_start <= start_now;
			if (start_now) begin
				run_reg     <= 1'b1;
				run_sel_reg <= lowest(pending_reg);
				run_cnt_reg <= 8'(ARRAY_CYCLES - 1);
				array_sel   <= lowest(pending_reg);
				array_kind  <= op_reg;
			end else if (run_reg) begin
				run_cnt_reg <= run_cnt_reg - 8'h1;
				if (run_cnt_reg == 8'h0) begin
					run_reg <= 1'b0;
				end
			end
			// New entry wins over the clear of a started selector
			for (int i = 0; i < NSEL; i++) begin
				if (op_done && sel_of(row_reg) == SEL_W'(i)) begin
					pending_reg[i] <= 1'b1;
				end else if (start_now && lowest(pending_reg) == SEL_W'(i)) begin
					pending_reg[i] <= 1'b0;
				end
			end
			if (op_done) begin
				stat_sel_reg <= sel_of(row_reg);
			end
			if (op_final) begin
				go_reg <= 1'b1;
			end else if (pending_reg == '0 && !run_reg) begin
				go_reg <= 1'b0;
			end
		end
	end

	// Tracking variables of the target
	always_ff @(posedge core_clk) begin
		if (rst) begin
			status_output_flag       <= 1'b0;
			column_change_allowed    <= 1'b0;
			copyback_active          <= 1'b0;
			enhanced_status_required <= 1'b0;
			selected_unit            <= '0;
			last_command_record      <= '0;
			return_state             <= 8'(nit_pkg::ST_POWER_UP);
		end else if (cmd_valid && bus_byte == nit_pkg::CMD_RESET &&
				state_reg != nit_pkg::ST_POWER_UP) begin
			last_command_record   <= nit_pkg::CMD_RESET;
			status_output_flag    <= 1'b0;
			column_change_allowed <= 1'b0;
			return_state          <= 8'(nit_pkg::ST_RESET);
		end else begin
			if (state_reg == nit_pkg::ST_IDLE) begin
				copyback_active <= 1'b0;
				return_state    <= 8'(nit_pkg::ST_IDLE);
			end
			if (state_reg == nit_pkg::ST_DECODE) begin
				if (cmd_reg == nit_pkg::CMD_STATUS || cmd_reg == nit_pkg::CMD_STATUS_ENH) begin
					status_output_flag <= 1'b1;
				end else begin
					last_command_record      <= cmd_reg;
					status_output_flag       <= 1'b0;
					enhanced_status_required <= 1'b0;
				end
				if (cmd_reg == nit_pkg::CMD_COPYBACK) begin
					copyback_active <= 1'b1;
				end
			end
		end
	end

	// Ready/busy, write-protect sampling and status output
	always_ff @(posedge core_clk) begin
		if (rst) begin
			unit_rdy_reg     <= 1'b0;
			rdy_busy         <= 1'b0;
			// Idle pin level, so no false change is seen after reset
			wp_seen_reg      <= 1'b1;
			unit_status_byte <= '0;
			status_valid     <= 1'b0;
		end else begin
			// Busy through reset and a concurrent sequence's array work
			unit_rdy_reg <= !(state_reg == nit_pkg::ST_POWER_UP ||
				state_reg == nit_pkg::ST_RESET || (go_reg && !overlap_mode));
			rdy_busy <= &{unit_rdy_reg};
			// Only seen in idle, so a mid-command change cannot glitch status
			if (state_reg == nit_pkg::ST_IDLE && wp_seen_reg != wp_n) begin
				wp_seen_reg <= wp_n;
			end
			status_valid <= read_req && status_output_flag;
			if (read_req && status_output_flag) begin
				unit_status_byte <= '0;
				unit_status_byte[nit_pkg::BIT_FAIL]      <= fail_stat[0];
				unit_status_byte[nit_pkg::BIT_PREV_FAIL] <= fail_stat[1];
				unit_status_byte[nit_pkg::BIT_ARRAY_RDY] <= !run_reg && pending_reg == '0;
				unit_status_byte[nit_pkg::BIT_READY]     <= unit_rdy_reg;
				unit_status_byte[nit_pkg::BIT_WP]        <= wp_seen_reg;
			end
		end
	end
endmodule
